// ### common/rtcsup_pkg.sv
package rtcsup_pkg;
    // ----------------------------------------------------------------
    // clocks and time figures
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000; // core clock rate
    localparam int XTAL_HZ = 32_768; // crystal rate
    localparam int WD_LONG_MS = 1750; // watchdog period, code 00
    localparam int WD_MID_MS = 750; // watchdog period, code 01
    localparam int WD_SHORT_MS = 250; // watchdog period, code 10
    localparam int WD_RST_MS = 250; // reset pulse after expiry
    localparam int PUR_MS = 250; // power-up reset time-out (100..400)
    localparam int NV_PROG_MS = 5; // typical programming time
    localparam int TRIM_STEP_PPM = 10; // digital trim step
    // derived counts, in crystal ticks or core cycles
    localparam int WD_LONG_TK = XTAL_HZ * WD_LONG_MS / 1000;
    localparam int WD_MID_TK = XTAL_HZ * WD_MID_MS / 1000;
    localparam int WD_SHORT_TK = XTAL_HZ * WD_SHORT_MS / 1000;
    localparam int WD_RST_TK = XTAL_HZ * WD_RST_MS / 1000;
    localparam int PUR_TK = XTAL_HZ * PUR_MS / 1000;
    localparam int NV_PROG_CYC = NV_PROG_MS * (CLK_HZ / 1000);
    localparam int TRIM_WIN_TK = 1_000_000 / TRIM_STEP_PPM;
    localparam int CW = 17; // width of the tick counters
    // ----------------------------------------------------------------
    // register map (byte offsets) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00; // watchdog select
    localparam logic [7:0] A_TRIM = 8'h04; // digital and analog trim
    localparam logic [7:0] A_KICK = 8'h08; // watchdog restart
    localparam logic [7:0] A_STAT = 8'h0c; // live state, read only
    localparam logic [7:0] A_ISTAT = 8'h10; // sticky events, w1c
    localparam logic [7:0] A_IMASK = 8'h14; // event mask
    localparam logic [7:0] A_NVCMD = 8'h18; // start programming cycle
    localparam int DIG_LSB = 0; // digital trim field {dir,mag[1:0]}
    localparam int ANA_LSB = 8; // analog load trim field, 6 bits
    localparam logic [1:0] WD_SEL_RST = 2'h0; // select after reset
    localparam logic [1:0] WD_SEL_MID = 2'h1;
    localparam logic [1:0] WD_SEL_SHORT = 2'h2;
    localparam logic [1:0] WD_SEL_OFF = 2'h3;
    localparam int EV_WD = 0; // event bit: watchdog expired
    localparam int EV_NV = 1; // event bit: programming done
    localparam int EV_PWR = 2; // event bit: power-up reset over
    localparam int NEV = 3; // number of event bits
endpackage : rtcsup_pkg

// ### common/rtcsup_tm_if.sv
`timescale 1ns/1ps
// timing signals shared by the core and its two helpers
interface rtcsup_tm_if;
    logic [2:0] trim_code; // digital trim {add_not_skip, steps}
    logic tick; // trimmed crystal tick, one cycle
    logic nv_start; // request a programming cycle
    logic nv_busy; // programming in progress
    logic nv_done; // programming finished, one cycle
    modport pre (input trim_code, output tick);
    modport nvw (input nv_start, output nv_busy, output nv_done);
    modport core (output trim_code, output nv_start,
                  input tick, input nv_busy, input nv_done);
endinterface : rtcsup_tm_if

// ### hw/rtcsup_prescale.sv
`timescale 1ns/1ps
// crystal tick generator with pulse add/skip rate trim
module rtcsup_prescale #(
    parameter int CLK_HZ = rtcsup_pkg::CLK_HZ,
    parameter int XTAL_HZ = rtcsup_pkg::XTAL_HZ,
    parameter int TRIM_WIN = rtcsup_pkg::TRIM_WIN_TK
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // timing carrier
    rtcsup_tm_if.pre tm
);
    localparam logic [31:0] INC = 32'(XTAL_HZ);
    localparam logic [31:0] MODV = 32'(CLK_HZ);
    localparam logic [16:0] WLAST = 17'(TRIM_WIN - 1);
    logic [31:0] acc_r, acc_nxt; // phase accumulator
    logic [16:0] win_r, win_nxt; // raw ticks in the trim window
    logic [1:0] left_r, left_nxt; // corrections still due
    logic add_r, add_nxt; // extra tick owed next cycle
    logic raw; // untrimmed crystal tick
    logic skip; // drop this raw tick
    // ----------------------------------------------------------------
    // next state: one raw tick whenever the phase wraps
    // ----------------------------------------------------------------
    always_comb begin
        raw = (acc_r + INC) >= MODV;
        acc_nxt = raw ? acc_r + INC - MODV : acc_r + INC;
        win_nxt = win_r;
        left_nxt = left_r;
        add_nxt = 1'b0;
        skip = 1'b0;
        if (raw) begin
            // each window of 1e5 ticks gets |code| x 10 ppm
            if (win_r == WLAST) begin
                win_nxt = '0;
                left_nxt = tm.trim_code[1:0];
            end else begin
                win_nxt = win_r + 17'h1;
            end
            if (left_r != 2'h0) begin
                left_nxt = left_r - 2'h1;
                skip = !tm.trim_code[2];
                add_nxt = tm.trim_code[2];
            end
        end
    end
    // extra tick lands between raw ticks, which are far apart
    assign tm.tick = (raw && !skip) || add_r;
    // ----------------------------------------------------------------
    // registers; trim starts with nothing owed
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_r <= '0;
            win_r <= '0;
            left_r <= '0;
            add_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            win_r <= win_nxt;
            left_r <= left_nxt;
            add_r <= add_nxt;
        end
    end
    skip_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (raw && left_r != 2'h0 && !tm.trim_code[2]) |-> !tm.tick)
        else $error("owed skip did not drop the tick");
    add_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (raw && left_r != 2'h0 && tm.trim_code[2]) |=> tm.tick)
        else $error("owed add did not insert a tick");
endmodule : rtcsup_prescale

// ### hw/rtcsup_nvwrite.sv
`timescale 1ns/1ps
// self-timed nonvolatile programming cycle
module rtcsup_nvwrite #(
    parameter int PROG_CYC = rtcsup_pkg::NV_PROG_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // timing carrier
    rtcsup_tm_if.nvw tm
);
    localparam logic [23:0] LAST = 24'(PROG_CYC - 1);
    logic [23:0] cnt_r, cnt_nxt; // cycles into the program cycle
    logic busy_r, busy_nxt; // cycle running
    logic done_r, done_nxt; // end pulse
    // ----------------------------------------------------------------
    // next state: a start while busy is ignored
    // ----------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (!busy_r) begin
            if (tm.nv_start) begin
                busy_nxt = 1'b1;
                cnt_nxt = '0;
            end
        end else if (cnt_r == LAST) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 24'h1;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end
    assign tm.nv_busy = busy_r;
    assign tm.nv_done = done_r;
    prog_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_r) |-> $past(cnt_r) == LAST && done_r)
        else $error("programming cycle length wrong");
    prog_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tm.nv_start && !busy_r) |=> busy_r && cnt_r == 24'h0)
        else $error("programming cycle did not start");
endmodule : rtcsup_nvwrite

// ### hw/rtcsup_top.sv
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module rtcsup_top #(
    parameter int CLK_HZ = rtcsup_pkg::CLK_HZ,
    parameter int XTAL_HZ = rtcsup_pkg::XTAL_HZ,
    parameter int WD_LONG_TK = rtcsup_pkg::WD_LONG_TK,
    parameter int WD_MID_TK = rtcsup_pkg::WD_MID_TK,
    parameter int WD_SHORT_TK = rtcsup_pkg::WD_SHORT_TK,
    parameter int WD_RST_TK = rtcsup_pkg::WD_RST_TK,
    parameter int PUR_TK = rtcsup_pkg::PUR_TK,
    parameter int TRIM_WIN = rtcsup_pkg::TRIM_WIN_TK,
    parameter int PROG_CYC = rtcsup_pkg::NV_PROG_CYC
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // supervisor outputs
    output logic RST_OUT_N_O,
    output logic [5:0] ANALOG_LOAD_TRIM_O,
    output logic IRQ_O
);
    localparam int CW = rtcsup_pkg::CW;
    localparam int NEV = rtcsup_pkg::NEV;
    localparam logic [CW-1:0] L_LONG = CW'(WD_LONG_TK - 1);
    localparam logic [CW-1:0] L_MID = CW'(WD_MID_TK - 1);
    localparam logic [CW-1:0] L_SHORT = CW'(WD_SHORT_TK - 1);
    localparam logic [CW-1:0] L_RST = CW'(WD_RST_TK - 1);
    localparam logic [CW-1:0] L_PUR = CW'(PUR_TK - 1);

    typedef enum {ST_PWRUP, ST_RUN, ST_WDRST} rtcsup_state_t;

    rtcsup_tm_if tm (); // carrier to the helpers

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    rtcsup_prescale #(
        .CLK_HZ(CLK_HZ),
        .XTAL_HZ(XTAL_HZ),
        .TRIM_WIN(TRIM_WIN)
    ) u_pre (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .tm(tm.pre)
    );
    rtcsup_nvwrite #(
        .PROG_CYC(PROG_CYC)
    ) u_nv (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .tm(tm.nvw)
    );

    // bus state
    logic wr_r, wr_nxt; // write data phase pending
    logic [7:0] wa_r, wa_nxt; // write address
    logic [31:0] rd_r, rd_nxt; // read data register
    // software registers
    logic [1:0] wsel_r, wsel_nxt; // {select_high, select_low}
    logic [2:0] dig_r, dig_nxt; // digital trim code
    logic [5:0] ana_r, ana_nxt; // analog load trim
    logic [NEV-1:0] ist_r, ist_nxt; // sticky events
    logic [NEV-1:0] imk_r, imk_nxt; // event mask
    logic dig_seen_r, dig_seen_nxt; // trim written since reset
    // supervisor state
    rtcsup_state_t st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt; // crystal ticks in this state
    logic rstn_r, rstn_nxt; // reset output, active low
    // strobes
    logic aphase; // valid address phase
    logic kick; // watchdog restart by software
    logic [NEV-1:0] ev; // event pulses this cycle
    logic [CW-1:0] wd_lim; // current watchdog limit
    logic [NEV-1:0] w1c; // bits cleared by software

    // ----------------------------------------------------------------
    // bus decode and register next values
    // ----------------------------------------------------------------
    always_comb begin
        aphase = HSEL_I && HREADY_I && HTRANS_I[1];
        wr_nxt = aphase && HWRITE_I;
        wa_nxt = aphase ? HADDR_I[7:0] : wa_r;
        wsel_nxt = wsel_r;
        dig_nxt = dig_r;
        ana_nxt = ana_r;
        imk_nxt = imk_r;
        dig_seen_nxt = dig_seen_r;
        kick = 1'b0;
        w1c = '0;
        tm.nv_start = 1'b0;
        if (wr_r) begin
            case (wa_r)
                rtcsup_pkg::A_CTRL: begin
                    wsel_nxt = HWDATA_I[1:0];
                    kick = 1'b1; // new period starts from zero
                end
                rtcsup_pkg::A_TRIM: begin
                    dig_nxt = HWDATA_I[rtcsup_pkg::DIG_LSB +: 3];
                    ana_nxt = HWDATA_I[rtcsup_pkg::ANA_LSB +: 6];
                    dig_seen_nxt = 1'b1;
                end
                rtcsup_pkg::A_KICK: kick = HWDATA_I[0];
                rtcsup_pkg::A_ISTAT: w1c = HWDATA_I[NEV-1:0];
                rtcsup_pkg::A_IMASK: imk_nxt = HWDATA_I[NEV-1:0];
                // a start while busy is dropped; host polls busy
                rtcsup_pkg::A_NVCMD: tm.nv_start = HWDATA_I[0];
                default: ; // unmapped or read-only: ignored
            endcase
        end
        // a new event beats a clear in the same cycle
        ist_nxt = (ist_r & ~w1c) | ev;
        rd_nxt = rd_r;
        if (aphase && !HWRITE_I) begin
            case (HADDR_I[7:0])
                rtcsup_pkg::A_CTRL: rd_nxt = {30'h0, wsel_r};
                rtcsup_pkg::A_TRIM: rd_nxt = {18'h0, ana_r, 5'h0, dig_r};
                rtcsup_pkg::A_STAT: rd_nxt = {28'h0, st_r == ST_RUN,
                    tm.nv_busy, st_r == ST_PWRUP, !rstn_r};
                rtcsup_pkg::A_ISTAT: rd_nxt = {29'h0, ist_r};
                rtcsup_pkg::A_IMASK: rd_nxt = {29'h0, imk_r};
                default: rd_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wr_r <= 1'b0;
            wa_r <= '0;
            rd_r <= '0;
            wsel_r <= rtcsup_pkg::WD_SEL_RST;
            dig_r <= '0;
            ana_r <= '0;
            ist_r <= '0;
            imk_r <= '0;
            dig_seen_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            wa_r <= wa_nxt;
            rd_r <= rd_nxt;
            wsel_r <= wsel_nxt;
            dig_r <= dig_nxt;
            ana_r <= ana_nxt;
            ist_r <= ist_nxt;
            imk_r <= imk_nxt;
            dig_seen_r <= dig_seen_nxt;
        end
    end

    assign tm.trim_code = dig_r;
    assign HRDATA_O = rd_r;
    assign HREADYOUT_O = 1'b1; // zero wait states
    assign HRESP_O = 1'b0; // always okay
    assign ANALOG_LOAD_TRIM_O = ana_r;
    assign IRQ_O = |(ist_r & imk_r);

    // ----------------------------------------------------------------
    // supervisor: power-up time-out, watchdog, reset pulse
    // ----------------------------------------------------------------
    always_comb begin
        case (wsel_r)
            rtcsup_pkg::WD_SEL_MID: wd_lim = L_MID;
            rtcsup_pkg::WD_SEL_SHORT: wd_lim = L_SHORT;
            default: wd_lim = L_LONG;
        endcase
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ev = '0;
        ev[rtcsup_pkg::EV_NV] = tm.nv_done;
        case (st_r)
            ST_PWRUP: begin
                if (tm.tick) begin
                    if (cnt_r == L_PUR) begin
                        st_nxt = ST_RUN;
                        cnt_nxt = '0;
                        ev[rtcsup_pkg::EV_PWR] = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // disabled code holds the count at zero
                if (kick || wsel_r == rtcsup_pkg::WD_SEL_OFF) begin
                    cnt_nxt = '0;
                end else if (tm.tick) begin
                    if (cnt_r == wd_lim) begin
                        st_nxt = ST_WDRST;
                        cnt_nxt = '0;
                        ev[rtcsup_pkg::EV_WD] = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            ST_WDRST: begin
                if (tm.tick) begin
                    if (cnt_r == L_RST) begin
                        st_nxt = ST_RUN;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            default: begin
                st_nxt = ST_PWRUP;
                cnt_nxt = '0;
            end
        endcase
        rstn_nxt = (st_nxt == ST_RUN);
    end

    // reset output is registered so it never glitches
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            st_r <= ST_PWRUP;
            cnt_r <= '0;
            rstn_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            rstn_r <= rstn_nxt;
        end
    end
    assign RST_OUT_N_O = rstn_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    wd_expire_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (st_r == ST_RUN && tm.tick && cnt_r == wd_lim && !kick &&
         wsel_r != rtcsup_pkg::WD_SEL_OFF) |=> !RST_OUT_N_O)
        else $error("watchdog expiry did not assert reset");
    wd_release_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        $rose(RST_OUT_N_O) |-> $past(cnt_r) == L_RST ||
        $past(cnt_r) == L_PUR)
        else $error("reset released before its time-out");
    pwr_hold_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (st_r == ST_PWRUP && !(tm.tick && cnt_r == L_PUR))
        |=> !RST_OUT_N_O)
        else $error("power-up reset released early");
    wd_off_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (st_r == ST_RUN && wsel_r == rtcsup_pkg::WD_SEL_OFF)
        |=> st_r == ST_RUN)
        else $error("disabled watchdog fired");
    trim_zero_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        !dig_seen_r |-> tm.trim_code == 3'h0)
        else $error("digital trim not zero after reset");
    ana_load_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (wr_r && wa_r == rtcsup_pkg::A_TRIM) |=>
        ANALOG_LOAD_TRIM_O == $past(HWDATA_I[rtcsup_pkg::ANA_LSB +: 6]))
        else $error("analog load trim not taken");
endmodule : rtcsup_top

// ### test/rtcsup_host.sv
`timescale 1ns/1ps
// bus master standing in for the host processor
module rtcsup_host #(
    // cycles after reset before the first read and the first write,
    // scaled like the bench's shortened crystal counts (1 ms vs 5 ms)
    parameter int RD_WAIT = 20,
    parameter int WR_WAIT = 100
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // ahb-lite master side
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [2:0] hsize_o,
    output logic [1:0] htrans_o,
    output logic [31:0] haddr_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    int up_cnt_r; // cycles since the supply became stable

    initial begin
        hsel_o = 1'b0;
        hsize_o = 3'h0;
        htrans_o = 2'h0;
        haddr_o = 32'h0;
        hwrite_o = 1'b0;
        hwdata_o = 32'h0;
    end

    // ----------------------------------------------------------------
    // power-up wait
    // ----------------------------------------------------------------
    // no read or write while the supply is still settling
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_cnt_r <= 0;
        end else if (up_cnt_r < WR_WAIT) begin
            up_cnt_r <= up_cnt_r + 1;
        end
    end

    // ----------------------------------------------------------------
    // single word transfer
    // ----------------------------------------------------------------
    // the answer is awaited, never assumed: the bench timeout cuts hangs
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        while (up_cnt_r < (w ? WR_WAIT : RD_WAIT)) @(posedge clk_i);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        hsize_o <= 3'h2;
        htrans_o <= 2'h2;
        haddr_o <= {24'h0, a};
        hwrite_o <= w;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_i;
    endtask : xfer
endmodule : rtcsup_host

// ### test/tb_rtcsup_top.sv
`timescale 1ns/1ps
module tb_rtcsup_top;
    localparam int TK = 10; // core cycles per crystal tick
    // shortened counts so the whole run stays a few thousand cycles
    localparam int XT_HZ = 10_000_000;
    localparam int LONG_TK = 20;
    localparam int MID_TK = 12;
    localparam int SHORT_TK = 8;
    localparam int RST_TK = 6;
    localparam int PWR_TK = 10;
    localparam int WIN_TK = 20;
    localparam int NV_CYC = 50;
    logic clk; // core clock
    logic rst; // async reset
    logic hsel; // slave select from the host
    logic [2:0] hsize; // transfer size from the host
    logic hready, hresp, hwrite, rst_n, irq; // bus and supervisor
    logic [1:0] htrans; // transfer kind
    logic [31:0] haddr, hwdata, hrdata, rd; // bus words
    logic [5:0] atrim; // load trim code out
    int failures = 0;
    int tests_run = 0;
    int cyc = 0; // free cycle count, also the timeout
    int n, t0;
    int lim[3] = '{LONG_TK, MID_TK, SHORT_TK}; // watchdog limits
    logic [31:0] tv[2] = '{32'h2a07, 32'h3f03}; // add 3, skip 3
    int tlo[2] = '{140, 220};
    int thi[2] = '{200, 280};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    rtcsup_top #(.XTAL_HZ(XT_HZ), .WD_LONG_TK(LONG_TK),
        .WD_MID_TK(MID_TK), .WD_SHORT_TK(SHORT_TK), .WD_RST_TK(RST_TK),
        .PUR_TK(PWR_TK), .TRIM_WIN(WIN_TK), .PROG_CYC(NV_CYC)) i_dut (
        .CORE_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .RST_OUT_N_O(rst_n),
        .ANALOG_LOAD_TRIM_O(atrim), .IRQ_O(irq));

    rtcsup_host i_host (.clk_i(clk), .rst_i(rst), .hready_i(hready),
        .hrdata_i(hrdata), .hsel_o(hsel), .hsize_o(hsize),
        .htrans_o(htrans), .haddr_o(haddr),
        .hwrite_o(hwrite), .hwdata_o(hwdata));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: %0d not in %0d..%0d", $time, got,
                     lo, hi);
        end
    endtask : chk_rng

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic rdreg(input logic [7:0] a);
        i_host.xfer(1'b0, a, 32'h0, rd);
    endtask : rdreg

    // cycles until reset out reaches a level, sampled mid-cycle
    task automatic hold(input logic lvl, output int c);
        c = 0;
        while (rst_n !== lvl && c < 3000) begin
            @(negedge clk);
            c++;
        end
    endtask : hold

    // restart with a select code and time the run to expiry
    task automatic period(input logic [1:0] sel, output int c);
        hold(1'b1, c);
        wr(rtcsup_pkg::A_CTRL, {30'h0, sel});
        hold(1'b0, c);
    endtask : period

    // timeout well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        hold(1'b1, n);
        chk_rng(n, PWR_TK * TK - 15, PWR_TK * TK + 15);
        chk_val({26'h0, atrim}, 32'h0);
        rdreg(rtcsup_pkg::A_TRIM);
        chk_val(rd, 32'h0);
        chk_val({31'h0, hresp}, 32'h0);
        // running, no programming, power-up over, reset out released
        rdreg(rtcsup_pkg::A_STAT);
        chk_val(rd, 32'h8);
        // power-up event raises, masks and clears the interrupt
        rdreg(rtcsup_pkg::A_ISTAT);
        chk_val(rd, 32'h4);
        wr(rtcsup_pkg::A_IMASK, 32'h7);
        repeat (2) @(negedge clk);
        chk_val({31'h0, irq}, 32'h1);
        wr(rtcsup_pkg::A_ISTAT, 32'h4);
        repeat (2) @(negedge clk);
        chk_val({31'h0, irq}, 32'h0);
        wr(rtcsup_pkg::A_IMASK, 32'h0);
        // unmapped place ignores writes and reads zero
        wr(8'h1c, 32'hffffffff);
        rdreg(8'h1c);
        chk_val(rd, 32'h0);
        // every enabled period, each followed by its reset pulse
        for (int s = 0; s < 3; s++) begin
            period(s[1:0], n);
            chk_rng(n, lim[s] * TK - 8, (lim[s] + 1) * TK + 12);
            hold(1'b1, n);
            chk_rng(n, (RST_TK - 1) * TK - 2, (RST_TK + 1) * TK + 2);
        end
        rdreg(rtcsup_pkg::A_ISTAT);
        chk_val(rd & 32'h1, 32'h1);
        chk_val({31'h0, irq}, 32'h0);
        wr(rtcsup_pkg::A_IMASK, 32'h1);
        repeat (2) @(negedge clk);
        chk_val({31'h0, irq}, 32'h1);
        // code 11 keeps reset out high however long we wait
        hold(1'b1, n);
        wr(rtcsup_pkg::A_CTRL, 32'h3);
        wr(rtcsup_pkg::A_ISTAT, 32'h1);
        n = 0;
        repeat (400) begin
            @(negedge clk);
            if (rst_n !== 1'b1) n++;
        end
        chk_rng(n, 0, 0);
        chk_val({31'h0, irq}, 32'h0);
        // kicks faster than the short period hold off expiry
        wr(rtcsup_pkg::A_CTRL, 32'h2);
        repeat (5) begin
            repeat (50) @(negedge clk);
            wr(rtcsup_pkg::A_KICK, 32'h1);
            chk_val({31'h0, rst_n}, 32'h1);
        end
        // pulse add then skip, with the analog field alongside
        for (int i = 0; i < 2; i++) begin
            hold(1'b1, n);
            wr(rtcsup_pkg::A_CTRL, 32'h3);
            wr(rtcsup_pkg::A_TRIM, tv[i]);
            repeat (2) @(negedge clk);
            chk_val({26'h0, atrim}, {26'h0, tv[i][13:8]});
            repeat (250) @(negedge clk);
            period(2'h0, n);
            chk_rng(n, tlo[i], thi[i]);
        end
        // programming cycle; a second start while busy is ignored
        hold(1'b1, n);
        wr(rtcsup_pkg::A_CTRL, 32'h3);
        wr(rtcsup_pkg::A_NVCMD, 32'h1);
        t0 = cyc;
        rdreg(rtcsup_pkg::A_STAT);
        chk_val(rd & 32'h4, 32'h4);
        wr(rtcsup_pkg::A_NVCMD, 32'h1);
        do begin
            rdreg(rtcsup_pkg::A_STAT);
        end while (rd[2] === 1'b1 && cyc - t0 < 500);
        chk_rng(cyc - t0, NV_CYC - 4, NV_CYC + 5);
        rdreg(rtcsup_pkg::A_ISTAT);
        chk_val(rd & 32'h2, 32'h2);
        end_sim();
    end
endmodule : tb_rtcsup_top
